/* File: rtl/acctl_regs.sv */
// Purpose: Serial-port register file, ADC scheduler, status pin, watchdog and charge gate
// Assumes: One 200 MHz clock; all pin inputs asynchronous to it
// Notes: Results capture the analog sample bus at the end of each conversion
`timescale 1ns/1ps
module acctl_regs #(
   parameter logic [6:0]  DEV_ADDR   = acctl_pkg::DEV_ADDR_DEF,
   parameter logic [31:0] MS_CYCLES  = 32'(acctl_pkg::MS_CYCLES_DEF),
   parameter logic [31:0] SEC_CYCLES = 32'(acctl_pkg::SEC_CYCLES_DEF)
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Serial register port
   input  wire logic                  scl_in,
   input  wire logic                  sda_in,
   output logic                       sda_out,
   output logic                       sda_oe,
   // Device pins and status
   input  wire logic                  vin_valid,
   input  wire logic                  pushbutton_n,
   input  wire logic                  charge_enable_n,
   input  wire logic [1:0]            status_pin_function_select,
   output logic                       status_pin_out,
   output logic                       status_pin_oe,
   output logic                       charge_allowed,
   output logic                       hw_reset_pulse,
   // Converter side
   input  wire acctl_pkg::acctl_sample_s sample,
   output logic                       conv_start,
   output logic                       conv_busy,
   output acctl_pkg::acctl_comp_s     comp_sources
);
   logic [acctl_pkg::SYNC_W-1:0] pins_raw, s1_q, s2_q, s3_q, flt_q;
   logic                         scl_prev_q, sda_prev_q;
   acctl_pkg::acctl_state_e      st_q, st_d;
   logic [3:0]                   cnt_q, cnt_d;
   logic [7:0]                   sh_q, sh_d, ptr_q, ptr_d, rd_data;
   logic                         rw_q, rw_d, low_q, low_d, nack_q, nack_d;
   logic [7:0]                   ic2_q, adc0_q, adc1_q, adc0_base, adc0_d;
   logic [7:0]                   vbat_hi_q, vbat_lo_q, ts_hi_q, ts_lo_q;
   logic                         busy_q, owned_q, pend_q, vin_prev_q, wd_armed_q;
   logic [31:0]                  conv_cnt_q, conv_len, sec_cnt_q, wd_cyc_q;
   logic [5:0]                   min_cnt_q;
   logic [3:0]                   wd_sec_q;

   // Three-stage pin filter: value moves only when stages two and three agree
   assign pins_raw = {charge_enable_n, pushbutton_n, vin_valid, sda_in, scl_in};
   for (genvar i = 0; i < acctl_pkg::SYNC_W; i++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            s1_q[i]  <= acctl_pkg::SYNC_RST[i];
            s2_q[i]  <= acctl_pkg::SYNC_RST[i];
            s3_q[i]  <= acctl_pkg::SYNC_RST[i];
            flt_q[i] <= acctl_pkg::SYNC_RST[i];
         end else begin
            s1_q[i] <= pins_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) flt_q[i] <= s3_q[i];
         end
      end
   end

   wire scl_f    = flt_q[acctl_pkg::SYNC_SCL];
   wire sda_f    = flt_q[acctl_pkg::SYNC_SDA];
   wire vin_f    = flt_q[acctl_pkg::SYNC_VIN];
   wire mr_n_f   = flt_q[acctl_pkg::SYNC_MR_N];
   wire ce_n_f   = flt_q[acctl_pkg::SYNC_CE_N];
   wire scl_rise = scl_f & ~scl_prev_q;
   wire scl_fall = ~scl_f & scl_prev_q;
   wire bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   wire bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
   wire byte_done = (cnt_q == acctl_pkg::BITS_PER_BYTE);
   wire addr_hit  = scl_fall & (st_q == acctl_pkg::ST_ADDR) & byte_done & (sh_q[7:1] == DEV_ADDR);
   wire wr_stb    = scl_fall & ~bus_stop & ~bus_start & (st_q == acctl_pkg::ST_WDATA) & byte_done;
   wire shifting  = (st_q == acctl_pkg::ST_ADDR) | (st_q == acctl_pkg::ST_REG)
                  | (st_q == acctl_pkg::ST_WDATA);

   // Read decode; unmapped offsets answer zero
   assign rd_data = (ptr_q == acctl_pkg::ADDR_IC_CONTROL_TWO)   ? ic2_q     :
                    (ptr_q == acctl_pkg::ADDR_ADC_CONTROL_ZERO) ? adc0_q    :
                    (ptr_q == acctl_pkg::ADDR_ADC_CONTROL_ONE)  ? adc1_q    :
                    (ptr_q == acctl_pkg::ADDR_VBAT_HIGH)        ? vbat_hi_q :
                    (ptr_q == acctl_pkg::ADDR_VBAT_LOW)         ? vbat_lo_q :
                    (ptr_q == acctl_pkg::ADDR_TS_HIGH)          ? ts_hi_q   :
                    (ptr_q == acctl_pkg::ADDR_TS_LOW)           ? ts_lo_q   :
                    acctl_pkg::READ_UNMAPPED;

   always_comb begin
      st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; ptr_d = ptr_q;
      rw_d = rw_q; low_d = low_q; nack_d = nack_q;
      if (bus_stop) begin
         st_d = acctl_pkg::ST_IDLE; low_d = 1'b0;
      end else if (bus_start) begin
         st_d = acctl_pkg::ST_ADDR; cnt_d = '0; low_d = 1'b0;
      end else if (scl_rise) begin
         if (shifting) begin
            sh_d  = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
         end
         if (st_q == acctl_pkg::ST_RACK) nack_d = sda_f;
      end else if (scl_fall) begin
         case (st_q)
            acctl_pkg::ST_ADDR: if (byte_done) begin
               if (addr_hit) begin
                  low_d = 1'b1; rw_d = sh_q[0]; st_d = acctl_pkg::ST_ADDR_ACK;
               end else st_d = acctl_pkg::ST_IDLE;
            end
            acctl_pkg::ST_REG: if (byte_done) begin
               ptr_d = sh_q; low_d = 1'b1; st_d = acctl_pkg::ST_REG_ACK;
            end
            acctl_pkg::ST_WDATA: if (byte_done) begin
               ptr_d = ptr_q + 8'h01; low_d = 1'b1; st_d = acctl_pkg::ST_WACK;
            end
            acctl_pkg::ST_ADDR_ACK, acctl_pkg::ST_RACK: begin
               if ((st_q == acctl_pkg::ST_ADDR_ACK) ? rw_q : ~nack_q) begin
                  sh_d = rd_data; low_d = ~rd_data[7]; cnt_d = 4'h1; st_d = acctl_pkg::ST_RDATA;
               end else if (st_q == acctl_pkg::ST_ADDR_ACK) begin
                  low_d = 1'b0; cnt_d = '0; st_d = acctl_pkg::ST_REG;
               end else st_d = acctl_pkg::ST_IDLE;
            end
            acctl_pkg::ST_REG_ACK, acctl_pkg::ST_WACK: begin
               low_d = 1'b0; cnt_d = '0; st_d = acctl_pkg::ST_WDATA;
            end
            acctl_pkg::ST_RDATA: if (byte_done) begin
               low_d = 1'b0; ptr_d = ptr_q + 8'h01; st_d = acctl_pkg::ST_RACK;
            end else begin
               low_d = ~sh_q[6]; sh_d = {sh_q[6:0], 1'b0}; cnt_d = cnt_q + 4'h1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= acctl_pkg::ST_IDLE; cnt_q <= '0; sh_q <= '0; ptr_q <= '0;
         rw_q <= 1'b0; low_q <= 1'b0; nack_q <= 1'b0;
         scl_prev_q <= 1'b1; sda_prev_q <= 1'b1;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; ptr_q <= ptr_d;
         rw_q <= rw_d; low_q <= low_d; nack_q <= nack_d;
         scl_prev_q <= scl_f; sda_prev_q <= sda_f;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = low_q;

   // Control registers; a fired watchdog restores defaults too
   wire wr_ic2  = wr_stb & (ptr_q == acctl_pkg::ADDR_IC_CONTROL_TWO);
   wire wr_adc0 = wr_stb & (ptr_q == acctl_pkg::ADDR_ADC_CONTROL_ZERO);
   wire wr_adc1 = wr_stb & (ptr_q == acctl_pkg::ADDR_ADC_CONTROL_ONE);
   wire trig_q  = adc0_q[acctl_pkg::ADC0_TRIG_BIT];
   wire [1:0] speed = adc0_q[acctl_pkg::ADC0_SPEED_LSB +: 2];
   wire [1:0] rate  = adc0_q[acctl_pkg::ADC0_RATE_LSB +: 2];
   wire conv_done   = busy_q & (conv_cnt_q == 32'h1);
   // Host set wins over the completion clear; writing 0 never aborts
   wire trig_set = wr_adc0 & sh_q[acctl_pkg::ADC0_TRIG_BIT];
   wire trig_d   = trig_set | (trig_q & ~(conv_done & owned_q));
   assign adc0_base = wr_adc0 ? sh_q : adc0_q;
   assign adc0_d = (adc0_base & ~acctl_pkg::ADC0_TRIG_MASK)
                 | (trig_d ? acctl_pkg::ADC0_TRIG_MASK : 8'h00);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ic2_q  <= acctl_pkg::RST_IC_CONTROL_TWO;
         adc0_q <= acctl_pkg::RST_ADC_CONTROL_ZERO;
         adc1_q <= acctl_pkg::RST_ADC_CONTROL_ONE;
      end else if (hw_reset_pulse) begin
         // Watchdog restore is synchronous, kept out of the async branch
         ic2_q  <= acctl_pkg::RST_IC_CONTROL_TWO;
         adc0_q <= acctl_pkg::RST_ADC_CONTROL_ZERO;
         adc1_q <= acctl_pkg::RST_ADC_CONTROL_ONE;
      end else begin
         if (wr_ic2) ic2_q <= sh_q;
         if (wr_adc1) adc1_q <= sh_q;
         adc0_q <= adc0_d;
      end
   end

   assign comp_sources.first  =
      acctl_pkg::acctl_chan_e'(adc0_q[acctl_pkg::ADC0_COMP1_LSB +: 3]);
   assign comp_sources.second = acctl_pkg::acctl_chan_e'(adc1_q[acctl_pkg::ADC1_COMP2_LSB +: 3]);
   assign comp_sources.third  = acctl_pkg::acctl_chan_e'(adc1_q[acctl_pkg::ADC1_COMP3_LSB +: 3]);

   // Status pin: open drain, only ever pulls low
   wire gpo_mode = status_pin_function_select[acctl_pkg::PIN_MODE_GPO_BIT];
   wire pg_mode  = (status_pin_function_select == acctl_pkg::PIN_MODE_POWER_GOOD);
   assign status_pin_out = 1'b0;
   assign status_pin_oe  = gpo_mode ? ~ic2_q[acctl_pkg::IC2_LEVEL_BIT] :
                           pg_mode  ? vin_f : ~mr_n_f;
   assign charge_allowed = ~ic2_q[acctl_pkg::IC2_CHG_DIS_BIT] & ~ce_n_f;

   // Rate ticks; a tick that lands mid-conversion is held, not lost
   wire sec_tick = (sec_cnt_q == SEC_CYCLES - 32'h1);
   wire min_tick = sec_tick & (min_cnt_q == 6'(acctl_pkg::RATE_MINUTE_S - 1));
   wire tick_sel = ~vin_f & (((rate == acctl_pkg::RATE_SECOND) & sec_tick)
                 | ((rate == acctl_pkg::RATE_MINUTE) & min_tick));
   wire auto_due = ~vin_f & ((rate == acctl_pkg::RATE_CONT) | pend_q);
   wire start_conv = ~busy_q & (trig_q | auto_due);
   assign conv_start = start_conv;
   assign conv_busy  = busy_q;

   always_comb begin
      case (speed)
         2'h0:    conv_len = 32'(acctl_pkg::CONV_MS_SPEED0) * MS_CYCLES;
         2'h1:    conv_len = 32'(acctl_pkg::CONV_MS_SPEED1) * MS_CYCLES;
         2'h2:    conv_len = 32'(acctl_pkg::CONV_MS_SPEED2) * MS_CYCLES;
         default: conv_len = 32'(acctl_pkg::CONV_MS_SPEED3) * MS_CYCLES;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0; owned_q <= 1'b0; pend_q <= 1'b0; conv_cnt_q <= '0;
         sec_cnt_q <= '0; min_cnt_q <= '0;
      end else begin
         sec_cnt_q <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
         if (sec_tick) min_cnt_q <= min_tick ? 6'h0 : min_cnt_q + 6'h1;
         pend_q <= tick_sel | (pend_q & ~start_conv);
         if (start_conv) begin
            busy_q <= 1'b1; owned_q <= trig_q; conv_cnt_q <= conv_len;
         end else if (busy_q) begin
            conv_cnt_q <= conv_cnt_q - 32'h1;
            if (conv_done) busy_q <= 1'b0;
         end
      end
   end

   // Results hold no reset value, by design
   always_ff @(posedge clk) begin
      if (conv_done) begin
         {vbat_hi_q, vbat_lo_q} <= sample.vbat;
         {ts_hi_q, ts_lo_q}     <= sample.therm;
      end
   end

   // Watchdog: armed when input power arrives, disarmed by any addressed access
   wire wd_sec_end = (wd_cyc_q == SEC_CYCLES - 32'h1);
   // An access landing in the final cycle still counts as in time
   wire wd_fire = wd_armed_q & ic2_q[acctl_pkg::IC2_WD_EN_BIT] & wd_sec_end & ~addr_hit
                & (wd_sec_q == 4'(acctl_pkg::WD_TIME_S - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vin_prev_q <= 1'b0; wd_armed_q <= 1'b0; wd_cyc_q <= '0; wd_sec_q <= '0;
         hw_reset_pulse <= 1'b0;
      end else begin
         vin_prev_q     <= vin_f;
         hw_reset_pulse <= wd_fire;
         if (vin_f & ~vin_prev_q) begin
            wd_armed_q <= 1'b1; wd_cyc_q <= '0; wd_sec_q <= '0;
         end else if (addr_hit | ~vin_f | wd_fire) begin
            wd_armed_q <= 1'b0;
         end else if (wd_armed_q) begin
            wd_cyc_q <= wd_sec_end ? 32'h0 : wd_cyc_q + 32'h1;
            if (wd_sec_end) wd_sec_q <= wd_sec_q + 4'h1;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [31:0] chk_cyc_q, chk_len_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chk_cyc_q <= '0; chk_len_q <= '0;
      end else if (start_conv) begin
         chk_cyc_q <= 32'h1; chk_len_q <= conv_len;
      end else if (busy_q) chk_cyc_q <= chk_cyc_q + 32'h1;
   end

   pin_low_a: assert property (gpo_mode && !ic2_q[acctl_pkg::IC2_LEVEL_BIT] |-> status_pin_oe)
      else $error("status pin not pulled low");
   pin_float_a: assert property (wr_ic2 && sh_q[acctl_pkg::IC2_LEVEL_BIT] && gpo_mode
      ##1 gpo_mode |-> !status_pin_oe)
      else $error("status pin not released");
   pin_mode_a: assert property (!gpo_mode |-> status_pin_oe == (pg_mode ? vin_f : !mr_n_f))
      else $error("status pin mode wrong");
   wd_gate_a: assert property (hw_reset_pulse |-> $past(ic2_q[acctl_pkg::IC2_WD_EN_BIT])
      && !$past(addr_hit))
      else $error("watchdog fired while disabled");
   charge_gate_a: assert property (charge_allowed |-> !ic2_q[acctl_pkg::IC2_CHG_DIS_BIT]
      && !ce_n_f)
      else $error("charging not gated");
   cont_rate_a: assert property (!vin_f && rate == acctl_pkg::RATE_CONT && !busy_q
      |=> busy_q)
      else $error("continuous mode idle");
   trig_start_a: assert property (trig_set && !busy_q && !conv_start
      |=> conv_start && trig_q ##1 busy_q)
      else $error("trigger did not start");
   trig_clear_a: assert property (conv_done && owned_q && !trig_set |=> !trig_q)
      else $error("trigger not cleared");
   conv_time_a: assert property (conv_done |-> chk_cyc_q == chk_len_q
      && chk_len_q != 32'h0)
      else $error("conversion length wrong");
   comp_two_a: assert property (wr_adc1 |=> comp_sources.second == $past(sh_q[7:5])
      && comp_sources.third == $past(sh_q[4:2]))
      else $error("comparator source not stored");
   vbat_cap_a: assert property (conv_done |=> {vbat_hi_q, vbat_lo_q} == $past(sample.vbat)
      && {ts_hi_q, ts_lo_q} == $past(sample.therm))
      else $error("result not captured");

   manual_conv_c: cover property (trig_set ##[1:1000] (conv_done && owned_q));
   auto_conv_c:   cover property (!vin_f && rate == acctl_pkg::RATE_SECOND && start_conv);
   wd_fire_c:     cover property (hw_reset_pulse);
   read_byte_c:   cover property ((st_q == acctl_pkg::ST_RDATA) && byte_done && scl_fall);
endmodule // acctl_regs

/* File: rtl/acctl_pkg.sv */
// Purpose: Shared constants and types for the ADC control and result register block
// Assumes: 200 MHz system clock, byte-wide register map reached over a two-wire serial port
// Notes: All offsets, reset values, field positions and times live here
// How it works
// - In general-purpose mode the status pin is pulled low when its level bit is 0 and floats when it is 1.
// - With the watchdog enable set, a hardware reset fires if no serial access occurs within 14 s of input power.
// - Charging is allowed only while the disable bit is 0 and the charge-enable pin is low.
// - On battery only, the rate field schedules conversions: manual, continuous, every second or every minute.
// - The trigger bit returns to 0 by itself when the conversion it started completes.
// - The speed field sets the conversion time to 24, 12, 6 or 3 ms.
// - Each comparator source is a 3-bit channel code, 0 meaning disabled.
// - The second comparator source sits in bits 7:5 of the second ADC control register, reset to thermistor.
// - The third source sits in bits 4:2 there, reset disabled; the first sits in bits 2:0 of the first, reset thermistor.
// - The battery result is read-only, upper byte then lower byte at the next address, reset undefined.
// - The thermistor result upper byte is read-only with an undefined reset value.
// - The thermistor result lower byte is read-only at the next address, reset undefined.
// - The status pin is a general-purpose output only in modes 10 and 11, else power good or button level.
package acctl_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_IC_CONTROL_TWO   = 8'h37;
   localparam logic [7:0] ADDR_ADC_CONTROL_ZERO = 8'h40;
   localparam logic [7:0] ADDR_ADC_CONTROL_ONE  = 8'h41;
   localparam logic [7:0] ADDR_VBAT_HIGH        = 8'h42;
   localparam logic [7:0] ADDR_VBAT_LOW         = 8'h43;
   localparam logic [7:0] ADDR_TS_HIGH          = 8'h44;
   localparam logic [7:0] ADDR_TS_LOW           = 8'h45;
   localparam logic [7:0] READ_UNMAPPED         = 8'h00;
   // Reset values
   localparam logic [7:0] RST_IC_CONTROL_TWO    = 8'h00;
   localparam logic [7:0] RST_ADC_CONTROL_ZERO  = 8'h02;
   localparam logic [7:0] RST_ADC_CONTROL_ONE   = 8'h40;
   // Field positions
   localparam int IC2_LEVEL_BIT   = 4;
   localparam int IC2_WD_EN_BIT   = 1;
   localparam int IC2_CHG_DIS_BIT = 0;
   localparam int ADC0_RATE_LSB   = 6;
   localparam int ADC0_TRIG_BIT   = 5;
   localparam int ADC0_SPEED_LSB  = 3;
   localparam int ADC0_COMP1_LSB  = 0;
   localparam int ADC1_COMP2_LSB  = 5;
   localparam int ADC1_COMP3_LSB  = 2;
   localparam logic [7:0] ADC0_TRIG_MASK = 8'h20;
   localparam int PIN_MODE_GPO_BIT = 1;
   localparam logic [1:0] PIN_MODE_POWER_GOOD = 2'h0;
   // Timing
   localparam int CLK_HZ         = 200_000_000;
   localparam int MS_PER_S       = 1000;
   localparam int CONV_MS_SPEED0 = 24;
   localparam int CONV_MS_SPEED1 = 12;
   localparam int CONV_MS_SPEED2 = 6;
   localparam int CONV_MS_SPEED3 = 3;
   localparam int WD_TIME_S      = 14;
   localparam int RATE_MINUTE_S  = 60;
   localparam int SEC_CYCLES_DEF = CLK_HZ;
   localparam int MS_CYCLES_DEF  = CLK_HZ / MS_PER_S;
   // Serial port; address value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h35;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Pin synchroniser lanes
   localparam int SYNC_W    = 5;
   localparam int SYNC_SCL  = 0;
   localparam int SYNC_SDA  = 1;
   localparam int SYNC_VIN  = 2;
   localparam int SYNC_MR_N = 3;
   localparam int SYNC_CE_N = 4;
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h1b;

   typedef enum logic [1:0] {
      RATE_MANUAL = 2'h0, RATE_CONT = 2'h1, RATE_SECOND = 2'h2, RATE_MINUTE = 2'h3
   } acctl_rate_e;

   typedef enum logic [2:0] {
      CH_OFF = 3'h0, CH_GP_IN = 3'h1, CH_THERM = 3'h2, CH_VBAT = 3'h3,
      CH_ICHG = 3'h4, CH_VIN = 3'h5, CH_SYSNODE = 3'h6, CH_IIN = 3'h7
   } acctl_chan_e;

   typedef enum logic [8:0] {
      ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_ADDR_ACK = 9'h004, ST_REG = 9'h008,
      ST_REG_ACK = 9'h010, ST_WDATA = 9'h020, ST_WACK = 9'h040, ST_RDATA = 9'h080,
      ST_RACK = 9'h100
   } acctl_state_e;

   typedef struct packed {
      logic [15:0] vbat;
      logic [15:0] therm;
   } acctl_sample_s;

   typedef struct packed {
      acctl_chan_e first;
      acctl_chan_e second;
      acctl_chan_e third;
   } acctl_comp_s;
endpackage

/* File: bench/acctl_host.sv */
// Purpose: Two-wire host model that runs register accesses on the serial port
// Assumes: Line pulled up; the bench forms its level from both pull-downs
// Notes: Eight-clock half bits keep each level well past the pin filter
`timescale 1ns/1ps
module acctl_host #(
   parameter logic [6:0] ADDR = acctl_pkg::DEV_ADDR_DEF
) (
   // Clock and line
   input  wire logic clk,
   input  wire logic sda_line,
   // Host drive
   output logic      scl,
   output logic      sda_low,
   output int        nak_cnt
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      nak_cnt = 0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Data moves only mid low phase, so the filter never sees a false start
   task automatic bit_io(input logic b, output logic r);
      hold(4);
      sda_low = ~b;
      hold(4);
      scl = 1'b1;
      hold(8);
      r = sda_line;
      scl = 1'b0;
   endtask
   task automatic start();
      hold(4);
      sda_low = 1'b0;
      hold(4);
      scl = 1'b1;
      hold(8);
      sda_low = 1'b1;
      hold(8);
      scl = 1'b0;
   endtask
   task automatic stop();
      hold(4);
      sda_low = 1'b1;
      hold(4);
      scl = 1'b1;
      hold(8);
      sda_low = 1'b0;
      hold(8);
   endtask
   // Ninth bit always released: ack on writes, final nack on reads
   task automatic xfer(input logic [7:0] d, input logic is_rd, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(1'b1, a);
      if (!is_rd && a !== 1'b0) begin
         nak_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({ADDR, 1'b0}, 1'b0, r);
      xfer(ra, 1'b0, r);
      xfer(d, 1'b0, r);
      stop();
   endtask
   task automatic rd(input logic [7:0] ra, output logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({ADDR, 1'b0}, 1'b0, r);
      xfer(ra, 1'b0, r);
      start();
      xfer({ADDR, 1'b1}, 1'b0, r);
      xfer(8'hff, 1'b1, d);
      stop();
   endtask
endmodule // acctl_host

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the ADC control register block
// Assumes: Short ms and second counts set through parameters
// Notes: All register traffic goes through the host model
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] MS = 32'h0000_000a;
   logic                     clk, rst, scl, sda_low, sda_out, sda_oe, input_supply_channel, pb_n, ce_n;
   logic                     pin_oe, pin_out, chg, hwr, c_start, busy;
   logic [1:0]               mode;
   logic [7:0]               rv;
   acctl_pkg::acctl_sample_s smp;
   acctl_pkg::acctl_comp_s   comp;
   int                       error_cnt = 0, tests_run = 0, blen = 0, bcnt = 0;
   int                       starts = 0, pulses = 0, nak, n;
   wire                      sda_line = ~(sda_low | (sda_oe & ~sda_out));
   acctl_regs #(.MS_CYCLES(MS), .SEC_CYCLES(32'h0000_0032)) u_dut (
      .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .vin_valid(input_supply_channel), .pushbutton_n(pb_n), .charge_enable_n(ce_n),
      .status_pin_function_select(mode), .status_pin_out(pin_out), .status_pin_oe(pin_oe),
      .charge_allowed(chg), .hw_reset_pulse(hwr), .sample(smp), .conv_start(c_start),
      .conv_busy(busy), .comp_sources(comp));
   acctl_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low),
      .nak_cnt(nak));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Busy length is latched when it drops, since writes return after short runs end
   always @(posedge clk) begin
      starts <= starts + int'(c_start === 1'b1);
      pulses <= pulses + int'(hwr === 1'b1);
      bcnt <= (busy === 1'b1) ? bcnt + 1 : 0;
      if (busy !== 1'b1 && bcnt != 0) begin
         blen <= bcnt;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, rv);
      chk(32'(rv), 32'(exp));
   endtask
   task automatic wt(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #400us;
      error_cnt++;
      finish_test();
   end
   initial begin
      rst = 1'b1;
      input_supply_channel = 1'b0;
      pb_n = 1'b1;
      ce_n = 1'b1;
      mode = 2'h0;
      smp = '0;
      wt(4);
      rst = 1'b0;
      rchk(8'h37, 8'h00);
      rchk(8'h40, 8'h02);
      rchk(8'h41, 8'h40);
      rchk(8'h00, 8'h00);
      chk(32'(comp), 32'h0000_0090);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         u_host.wr(8'h40, 8'(c));
         u_host.wr(8'h41, {3'(c), 3'(7 - c), 2'h0});
         chk(32'(comp), 32'({3'(c), 3'(c), 3'(7 - c)}));
      end
      rchk(8'h41, 8'he0);
      $display("test channels done");
      for (int s = 0; s < 4; s++) begin
         smp = {8'h81, 8'(s), 8'h3c, 8'(s + 8'h70)};
         u_host.wr(8'h40, {2'h0, 1'b1, 2'(s), 3'h0});
         for (int i = 0; i < 400 && busy !== 1'b0; i++) wt(1);
         wt(4);
         chk(32'(blen), MS * (32'h18 >> s));
         rchk(8'h40, {3'h0, 2'(s), 3'h0});
      end
      n = starts;
      u_host.wr(8'h40, 8'h00);
      u_host.wr(8'h42, 8'h00);
      rchk(8'h42, 8'h81);
      rchk(8'h43, 8'h03);
      rchk(8'h44, 8'h3c);
      rchk(8'h45, 8'h73);
      chk(32'(starts - n), 32'h0);
      $display("test manual done");
      n = starts;
      u_host.wr(8'h40, 8'h58);
      wt(200);
      chk(32'(starts - n >= 6 && starts - n <= 9), 32'h1);
      u_host.wr(8'h40, 8'h98);
      n = starts;
      wt(500);
      chk(32'(starts - n >= 9 && starts - n <= 11), 32'h1);
      u_host.wr(8'h40, 8'hd8);
      n = starts;
      wt(6100);
      chk(32'(starts - n >= 2 && starts - n <= 3), 32'h1);
      input_supply_channel = 1'b1;
      wt(300);
      n = starts;
      u_host.wr(8'h40, 8'h58);
      wt(300);
      chk(32'(starts - n), 32'h0);
      $display("test rate done");
      chk(32'(pin_oe), 32'h1);
      pb_n = 1'b0;
      mode = 2'h1;
      wt(8);
      chk(32'(pin_oe), 32'h1);
      pb_n = 1'b1;
      wt(8);
      chk(32'(pin_oe), 32'h0);
      for (int m = 2; m < 4; m++) begin
         for (int l = 0; l < 2; l++) begin
            mode = 2'(m);
            u_host.wr(8'h37, {3'h0, 1'(l), 4'h0});
            chk(32'(pin_oe), 32'(1 - l));
         end
      end
      chk(32'(pin_out), 32'h0);
      ce_n = 1'b0;
      u_host.wr(8'h37, 8'h00);
      chk(32'(chg), 32'h1);
      ce_n = 1'b1;
      wt(8);
      chk(32'(chg), 32'h0);
      ce_n = 1'b0;
      u_host.wr(8'h37, 8'h01);
      chk(32'(chg), 32'h0);
      $display("test pins done");
      input_supply_channel = 1'b0;
      u_host.wr(8'h37, 8'h02);
      n = pulses;
      input_supply_channel = 1'b1;
      wt(680);
      chk(32'(pulses - n), 32'h0);
      wt(50);
      chk(32'(pulses - n), 32'h1);
      rchk(8'h37, 8'h00);
      input_supply_channel = 1'b0;
      u_host.wr(8'h37, 8'h02);
      input_supply_channel = 1'b1;
      wt(300);
      rchk(8'h00, 8'h00);
      wt(700);
      chk(32'(pulses - n), 32'h1);
      chk(32'(nak), 32'h0);
      $display("test watchdog done");
      finish_test();
   end
endmodule // tb
